// file: core/cxs_pkg.sv
package cxs_pkg;

    // ------------------------------------------------------------
    // Widths and operand ranges.
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // ------------------------------------------------------------
    // Direction-load operand codes.
    // ------------------------------------------------------------
    localparam logic [2:0] DIR_SEL_A = 3'h5;
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;

    // ------------------------------------------------------------
    // Destination select values.
    // ------------------------------------------------------------
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // ------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic PD_RESET = 1'h1;
    localparam logic TO_RESET = 1'h1;

    // ------------------------------------------------------------
    // Operation codes handed in by the decoder.
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CXS_OP_NONE = 3'h0,
        CXS_OP_SUB = 3'h1,
        CXS_OP_SUBB = 3'h2,
        CXS_OP_SWAP = 3'h3,
        CXS_OP_XORL = 3'h4,
        CXS_OP_XORF = 3'h5,
        CXS_OP_DIR = 3'h6,
        CXS_OP_HALT = 3'h7
    } cxs_op_t;

    // Core run state, Gray coded along run to halted.
    typedef enum logic [0:0] {
        CXS_RUN = 1'h0,
        CXS_HALTED = 1'h1
    } cxs_state_t;

endpackage : cxs_pkg

// file: core/cxs_subtractor.sv
`timescale 1ns/10ps
// Subtracts b and a borrow from a, reporting no-borrow out of the
// low nibble and of the whole byte, as the carry flags expect.
module cxs_subtractor
#(
    parameter int W = 8
)
(
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire logic i_borrow,
    output logic [W-1:0] o_diff,
    output logic o_carry,
    output logic o_half
);
    logic [W:0] full;
    logic [4:0] low;

    // Adding the inverted operand plus one turns carry into not-borrow.
    always_comb
    begin
        full = {1'b0, i_a} + {1'b0, ~i_b} + {{W{1'b0}}, ~i_borrow};
        low = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + {4'h0, ~i_borrow};
        o_diff = full[W-1:0];
        o_carry = full[W];
        o_half = low[4];
    end
endmodule : cxs_subtractor

// file: core/cxs_exec.sv
`timescale 1ns/10ps
// Operation
// - Destination bit picks accumulator or file.
// - Halt clears power-down flag, sets expiry flag.
// - Halt clears watchdog counter and prescaler.
// - Halt enters low power, stops oscillator.
// - Subtract gives file minus accumulator, flags.
// - Borrow subtract uses inverted carry as borrow.
// - Nibble exchange swaps halves, flags untouched.
// - Literal XOR to accumulator, zero flag only.
// - File XOR routed by destination, zero only.
// - Direction load: 5 A, 6 B, 7 C.
module cxs_exec
    import cxs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire cxs_pkg::cxs_op_t i_op,
    input wire logic i_dest,
    input wire logic [cxs_pkg::ADDR_W-1:0] i_faddr,
    input wire logic [cxs_pkg::DATA_W-1:0] i_fdata,
    input wire logic [cxs_pkg::DATA_W-1:0] i_literal,
    input wire logic [2:0] i_dir_sel,
    input wire logic i_wake,
    output logic [cxs_pkg::DATA_W-1:0] o_acc,
    output logic o_file_we,
    output logic [cxs_pkg::ADDR_W-1:0] o_file_addr,
    output logic [cxs_pkg::DATA_W-1:0] o_file_wdata,
    output logic o_carry,
    output logic o_half_arith_out_flag,
    output logic o_zero,
    output logic o_power_down_flag,
    output logic o_expiry_status_flag,
    output logic o_watchdog_clear,
    output logic o_osc_stop,
    output logic o_halted,
    output logic [cxs_pkg::DATA_W-1:0] o_port_a_direction,
    output logic [cxs_pkg::DATA_W-1:0] o_port_b_direction,
    output logic [cxs_pkg::DATA_W-1:0] o_port_c_direction
);
    import cxs_pkg::*;

    // ------------------------------------------------------------
    // Arithmetic.
    // ------------------------------------------------------------
    logic [DATA_W-1:0] diff;
    logic sub_c;
    logic sub_dc;
    logic use_borrow;

    // Plain subtract runs with no borrow; the borrow form feeds ~C.
    assign use_borrow = (i_op == CXS_OP_SUBB) ? ~o_carry : 1'b0;

    cxs_subtractor #(
        .W(DATA_W)
    ) u_sub (
        .i_a(i_fdata),
        .i_b(o_acc),
        .i_borrow(use_borrow),
        .o_diff(diff),
        .o_carry(sub_c),
        .o_half(sub_dc)
    );

    // ------------------------------------------------------------
    // Next-state computation.
    // ------------------------------------------------------------
    cxs_state_t state;
    cxs_state_t next_state;
    logic [DATA_W-1:0] next_acc;
    logic next_file_we;
    logic [ADDR_W-1:0] next_file_addr;
    logic [DATA_W-1:0] next_file_wdata;
    logic next_carry;
    logic next_half;
    logic next_zero;
    logic next_pd;
    logic next_to;
    logic next_wdt_clr;
    logic [DATA_W-1:0] next_dir_a;
    logic [DATA_W-1:0] next_dir_b;
    logic [DATA_W-1:0] next_dir_c;
    logic [DATA_W-1:0] result;
    logic routed;
    logic go;
    logic next_halted;

    // Instructions are ignored while halted; only a wake resumes the core.
    always_comb
    begin
        go = i_valid && (state == CXS_RUN);
        next_state = state;
        next_acc = o_acc;
        next_file_we = 1'b0;
        next_file_addr = o_file_addr;
        next_file_wdata = o_file_wdata;
        next_carry = o_carry;
        next_half = o_half_arith_out_flag;
        next_zero = o_zero;
        next_pd = o_power_down_flag;
        next_to = o_expiry_status_flag;
        next_wdt_clr = 1'b0;
        next_dir_a = o_port_a_direction;
        next_dir_b = o_port_b_direction;
        next_dir_c = o_port_c_direction;
        result = diff;
        routed = 1'b0;
        case (state)
            CXS_RUN:
            begin
                if (go)
                begin
                    case (i_op)
                        CXS_OP_SUB, CXS_OP_SUBB:
                        begin
                            result = diff;
                            routed = 1'b1;
                            next_carry = sub_c;
                            next_half = sub_dc;
                            next_zero = (diff == 8'h00);
                        end
                        CXS_OP_SWAP:
                        begin
                            result = {i_fdata[3:0], i_fdata[7:4]};
                            routed = 1'b1;
                        end
                        CXS_OP_XORL:
                        begin
                            next_acc = o_acc ^ i_literal;
                            next_zero = ((o_acc ^ i_literal) == 8'h00);
                        end
                        CXS_OP_XORF:
                        begin
                            result = o_acc ^ i_fdata;
                            routed = 1'b1;
                            next_zero = (result == 8'h00);
                        end
                        CXS_OP_DIR:
                        begin
                            case (i_dir_sel)
                                DIR_SEL_A: next_dir_a = o_acc;
                                DIR_SEL_B: next_dir_b = o_acc;
                                DIR_SEL_C: next_dir_c = o_acc;
                                default: next_dir_a = o_port_a_direction;
                            endcase
                        end
                        CXS_OP_HALT:
                        begin
                            next_pd = 1'b0;
                            next_to = 1'b1;
                            next_wdt_clr = 1'b1;
                            next_state = CXS_HALTED;
                        end
                        default: next_state = state;
                    endcase
                    // The destination bit only applies to file-operand forms.
                    if (routed)
                    begin
                        if (i_dest == DEST_FILE)
                        begin
                            next_file_we = 1'b1;
                            next_file_addr = i_faddr;
                            next_file_wdata = result;
                        end
                        else
                        begin
                            next_acc = result;
                        end
                    end
                end
            end
            CXS_HALTED:
            begin
                if (i_wake)
                begin
                    next_state = CXS_RUN;
                end
            end
            default: next_state = CXS_RUN;
        endcase
        // Halted level outputs follow the state that this edge will enter.
        next_halted = (next_state == CXS_HALTED);
    end

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    // Direction registers reset to all inputs, the safe pin state.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= CXS_RUN;
            o_acc <= ACC_RESET;
            o_file_we <= 1'b0;
            o_file_addr <= '0;
            o_file_wdata <= '0;
            o_carry <= 1'b0;
            o_half_arith_out_flag <= 1'b0;
            o_zero <= 1'b0;
            o_power_down_flag <= PD_RESET;
            o_expiry_status_flag <= TO_RESET;
            o_watchdog_clear <= 1'b0;
            o_osc_stop <= 1'b0;
            o_halted <= 1'b0;
            o_port_a_direction <= DIR_RESET;
            o_port_b_direction <= DIR_RESET;
            o_port_c_direction <= DIR_RESET;
        end
        else
        begin
            state <= next_state;
            o_acc <= next_acc;
            o_file_we <= next_file_we;
            o_file_addr <= next_file_addr;
            o_file_wdata <= next_file_wdata;
            o_carry <= next_carry;
            o_half_arith_out_flag <= next_half;
            o_zero <= next_zero;
            o_power_down_flag <= next_pd;
            o_expiry_status_flag <= next_to;
            o_watchdog_clear <= next_wdt_clr;
            o_osc_stop <= next_halted;
            o_halted <= next_halted;
            o_port_a_direction <= next_dir_a;
            o_port_b_direction <= next_dir_b;
            o_port_c_direction <= next_dir_c;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    sequence halt_issued;
        i_valid && !o_halted && i_op == CXS_OP_HALT;
    endsequence

    sequence halt_done;
        !o_power_down_flag && o_expiry_status_flag && o_watchdog_clear && o_osc_stop;
    endsequence

    halt_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        halt_issued |=> halt_done)
        else $error("halt did not update status and watchdog");

    wdt_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_watchdog_clear |=> !o_watchdog_clear)
        else $error("watchdog clear lasted more than one cycle");

    osc_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_halted && !i_wake) |=> o_osc_stop && o_halted)
        else $error("oscillator restarted without wake");

    sub_value_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_SUB && i_dest == DEST_ACC) |=>
        o_acc == $past(i_fdata) - $past(o_acc) &&
        o_carry == ($past(o_acc) <= $past(i_fdata)) &&
        o_half_arith_out_flag == ($past(o_acc[3:0]) <= $past(i_fdata[3:0])))
        else $error("subtract result or flags wrong");

    subb_value_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_SUBB && i_dest == DEST_FILE) |=>
        o_file_we && o_file_wdata == 8'($past(i_fdata) - $past(o_acc) - {7'h0, !$past(o_carry)}))
        else $error("borrow subtract result wrong");

    swap_keep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_SWAP && i_dest == DEST_ACC) |=>
        o_acc == {$past(i_fdata[3:0]), $past(i_fdata[7:4])} && $stable(o_carry) && $stable(o_zero))
        else $error("nibble exchange wrong or flags changed");

    xorl_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_XORL) |=>
        o_acc == ($past(o_acc) ^ $past(i_literal)) && o_zero == (o_acc == 8'h00) &&
        $stable(o_carry) && !o_file_we)
        else $error("literal xor wrong");

    xorf_route_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_XORF && i_dest == DEST_FILE) |=>
        o_file_we && o_file_wdata == ($past(o_acc) ^ $past(i_fdata)) &&
        o_file_addr == $past(i_faddr) && $stable(o_acc) && $stable(o_half_arith_out_flag))
        else $error("file xor routing wrong");

    dir_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_DIR && i_dir_sel == DIR_SEL_B) |=>
        o_port_b_direction == $past(o_acc) && $stable(o_port_a_direction) && $stable(o_zero))
        else $error("direction load wrong");

    // Routing and refusal cases; a stray write here would corrupt the register file.
    acc_dest_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_dest == DEST_ACC &&
        (i_op == CXS_OP_SUB || i_op == CXS_OP_SWAP || i_op == CXS_OP_XORF)) |=>
        !o_file_we && $stable(o_file_wdata))
        else $error("accumulator destination wrote the file");

    sub_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && (i_op == CXS_OP_SUB || i_op == CXS_OP_SUBB) &&
        i_dest == DEST_FILE) |=> o_file_we && o_zero == (o_file_wdata == 8'h00))
        else $error("zero flag does not match subtract result");

    dir_ignore_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && !o_halted && i_op == CXS_OP_DIR && i_dir_sel < DIR_SEL_A) |=>
        $stable(o_port_a_direction) && $stable(o_port_b_direction) &&
        $stable(o_port_c_direction))
        else $error("direction register loaded by an unused operand");

    halt_refuse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_valid && o_halted) |=>
        $stable(o_acc) && !o_file_we && $stable(o_zero) && $stable(o_port_a_direction))
        else $error("instruction executed while halted");

endmodule : cxs_exec

// file: bench/cxs_exec_tb.sv
`timescale 1ns/10ps
module cxs_exec_tb;
    import cxs_pkg::*;

    // ------------------------------------------------------------
    // Signals and reference state.
    // ------------------------------------------------------------
    logic i_clk;
    logic i_resetn;
    logic i_valid;
    cxs_op_t i_op;
    logic i_dest;
    logic i_wake;
    logic [6:0] i_faddr;
    logic [6:0] o_file_addr;
    logic [2:0] i_dir_sel;
    logic [7:0] i_fdata, i_literal, o_acc, o_file_wdata;
    logic [7:0] o_port_a_direction, o_port_b_direction, o_port_c_direction;
    logic o_file_we, o_carry, o_half_arith_out_flag, o_zero, o_power_down_flag;
    logic o_expiry_status_flag, o_watchdog_clear, o_osc_stop, o_halted;
    logic [7:0] m_acc;
    logic m_c, m_dc, m_z;
    int n_fail;
    int checks_done;

    cxs_exec dut_u (
        .i_clk, .i_resetn, .i_valid, .i_op, .i_dest, .i_faddr, .i_fdata, .i_literal,
        .i_dir_sel, .i_wake, .o_acc, .o_file_we, .o_file_addr, .o_file_wdata, .o_carry,
        .o_half_arith_out_flag, .o_zero, .o_power_down_flag, .o_expiry_status_flag,
        .o_watchdog_clear, .o_osc_stop, .o_halted, .o_port_a_direction,
        .o_port_b_direction, .o_port_c_direction
    );

    // Free-running 125 MHz clock.
    initial i_clk = 1'b0;
    always #4 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // Presents one instruction for a single edge; returns while pulses still stand.
    task automatic step(input cxs_op_t op, input logic d, input logic [6:0] fa,
                        input logic [7:0] f, input logic [7:0] lit, input logic [2:0] ds);
        @(negedge i_clk);
        i_valid = 1'b1;
        i_op = op;
        i_dest = d;
        i_faddr = fa;
        i_fdata = f;
        i_literal = lit;
        i_dir_sel = ds;
        @(negedge i_clk);
        i_valid = 1'b0;
    endtask : step

    task automatic chk_state();
        check(o_acc, m_acc);
        check(8'(o_carry), 8'(m_c));
        check(8'(o_half_arith_out_flag), 8'(m_dc));
        check(8'(o_zero), 8'(m_z));
    endtask : chk_state

    // Works out the expected result from the reference state, then executes and compares.
    // Borrow is modelled as adding the inverted accumulator plus carry-in.
    task automatic run(input cxs_op_t op, input logic d, input logic [6:0] fa,
                       input logic [7:0] f, input logic [7:0] lit);
        logic [8:0] r9;
        logic [4:0] h5;
        logic cin;
        logic wr;
        cin = (op == CXS_OP_SUB) ? 1'b1 : m_c;
        r9 = {1'b0, f} + {1'b0, ~m_acc} + {8'h00, cin};
        h5 = {1'b0, f[3:0]} + {1'b0, ~m_acc[3:0]} + {4'h0, cin};
        wr = (d == DEST_FILE) && (op != CXS_OP_XORL);
        if (op == CXS_OP_SWAP)
            r9[7:0] = {f[3:0], f[7:4]};
        if (op == CXS_OP_XORL)
            r9[7:0] = m_acc ^ lit;
        if (op == CXS_OP_XORF)
            r9[7:0] = m_acc ^ f;
        if (op == CXS_OP_SUB || op == CXS_OP_SUBB)
        begin
            m_c = r9[8];
            m_dc = h5[4];
        end
        if (op != CXS_OP_SWAP)
            m_z = (r9[7:0] == 8'h00);
        if (!wr)
            m_acc = r9[7:0];
        step(op, d, fa, f, lit, 3'h0);
        chk_state();
        check(8'(o_file_we), 8'(wr));
        if (wr)
        begin
            check({1'b0, o_file_addr}, {1'b0, fa});
            check(o_file_wdata, r9[7:0]);
        end
    endtask : run

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_state();
        check(8'(o_power_down_flag), 8'h01);
        check(8'(o_expiry_status_flag), 8'h01);
        check(8'(o_halted), 8'h00);
        check(8'(o_osc_stop), 8'h00);
        check(8'(o_file_we), 8'h00);
        check(o_port_a_direction, DIR_RESET);
        check(o_port_b_direction, DIR_RESET);
        check(o_port_c_direction, DIR_RESET);
        $display("reset test done");
    endtask : t_reset

    // Literal XOR, the destination bit ignored, then two back to back.
    task automatic t_xorl();
        run(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h5a);
        run(CXS_OP_XORL, 1'b1, 7'h11, 8'h00, 8'h5a);
        run(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'hff);
        @(negedge i_clk);
        i_valid = 1'b1;
        i_op = CXS_OP_XORL;
        i_literal = 8'h0f;
        @(negedge i_clk);
        i_literal = 8'hf0;
        @(negedge i_clk);
        i_valid = 1'b0;
        m_acc = m_acc ^ 8'hff;
        m_z = (m_acc == 8'h00);
        chk_state();
        $display("xor literal test done");
    endtask : t_xorl

    // Equal operands, accumulator above file, and borrow in with carry clear.
    task automatic t_sub();
        run(CXS_OP_SUB, 1'b0, 7'h01, 8'h00, 8'h00);
        run(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h21);
        run(CXS_OP_SUB, 1'b1, 7'h7f, 8'h13, 8'h00);
        run(CXS_OP_SUBB, 1'b1, 7'h40, 8'h30, 8'h00);
        run(CXS_OP_SUBB, 1'b0, 7'h02, 8'h30, 8'h00);
        run(CXS_OP_SUB, 1'b1, 7'h03, 8'h00, 8'h00);
        run(CXS_OP_SUBB, 1'b1, 7'h04, 8'h0f, 8'h00);
        $display("subtract test done");
    endtask : t_sub

    task automatic t_swap_xorf();
        run(CXS_OP_SWAP, 1'b0, 7'h7f, 8'h3c, 8'h00);
        run(CXS_OP_SWAP, 1'b1, 7'h55, 8'h00, 8'h00);
        run(CXS_OP_XORF, 1'b1, 7'h2a, 8'hc3, 8'h00);
        run(CXS_OP_XORF, 1'b0, 7'h2a, 8'h0f, 8'h00);
        $display("swap and xor file test done");
    endtask : t_swap_xorf

    // Operand 4 must leave every direction register alone.
    task automatic t_dir();
        logic [7:0] m_dir [3];
        m_dir = '{8'hff, 8'hff, 8'hff};
        for (int s = 4; s < 8; s++)
        begin
            run(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'(s * 17));
            if (s > 4)
                m_dir[s-5] = m_acc;
            step(CXS_OP_DIR, 1'b0, 7'h00, 8'h00, 8'h00, 3'(s));
            chk_state();
            check(o_port_a_direction, m_dir[0]);
            check(o_port_b_direction, m_dir[1]);
            check(o_port_c_direction, m_dir[2]);
        end
        $display("direction test done");
    endtask : t_dir

    // Halt, an instruction refused while halted, then wake.
    task automatic t_halt();
        step(CXS_OP_HALT, 1'b0, 7'h00, 8'h00, 8'h00, 3'h0);
        check(8'(o_power_down_flag), 8'h00);
        check(8'(o_expiry_status_flag), 8'h01);
        check(8'(o_watchdog_clear), 8'h01);
        check(8'(o_osc_stop), 8'h01);
        check(8'(o_halted), 8'h01);
        step(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'hff, 3'h0);
        check(8'(o_watchdog_clear), 8'h00);
        check(8'(o_halted), 8'h01);
        chk_state();
        i_wake = 1'b1;
        @(negedge i_clk);
        i_wake = 1'b0;
        check(8'(o_osc_stop), 8'h00);
        check(8'(o_halted), 8'h00);
        $display("halt test done");
    endtask : t_halt

    // Reset while halted must bring the core back to run with fresh status.
    task automatic t_rst_mid();
        step(CXS_OP_HALT, 1'b0, 7'h00, 8'h00, 8'h00, 3'h0);
        check(8'(o_halted), 8'h01);
        check(8'(o_power_down_flag), 8'h00);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clk);
        i_resetn = 1'b1;
        m_acc = ACC_RESET;
        m_c = 1'b0;
        m_dc = 1'b0;
        m_z = 1'b0;
        t_reset();
        run(CXS_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h3c);
        $display("mid-run reset test done");
    endtask : t_rst_mid

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial
    begin
        i_resetn = 1'b0;
        i_valid = 1'b0;
        i_op = CXS_OP_NONE;
        i_dest = 1'b0;
        i_faddr = 7'h00;
        i_fdata = 8'h00;
        i_literal = 8'h00;
        i_dir_sel = 3'h0;
        i_wake = 1'b0;
        m_acc = ACC_RESET;
        m_c = 1'b0;
        m_dc = 1'b0;
        m_z = 1'b0;
        n_fail = 0;
        checks_done = 0;
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        t_reset();
        t_xorl();
        t_sub();
        t_swap_xorf();
        t_dir();
        t_halt();
        t_rst_mid();
        test_done();
    end

endmodule : cxs_exec_tb
